// ==== verilog/bsbt_exec.sv ====
// Execution datapath: decimal string subtract, borrow subtract, AND
// compare, single bit probe and byte table lookup.
// Assumes the decoder holds operands stable from the start cycle until done and a
// byte memory port on the same clock that answers with a one cycle ack.
`timescale 1ns/1ps
`default_nettype none
`include "bsbt_defines.svh"

module bsbt_exec
  import bsbt_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire bsbt_op_t      op,
  input  wire logic          op_word,
  input  wire logic          acc_form,
  input  wire logic [7:0]    opc0,
  input  wire logic [7:0]    opc1,
  input  wire logic [7:0]    opc2,
  input  wire logic [7:0]    imm_byte,
  input  wire logic [15:0]   dst_operand,
  input  wire logic [15:0]   src_operand,
  input  wire logic [7:0]    count_low_reg,
  input  wire logic [15:0]   accum_word,
  input  wire logic [15:0]   base_word_reg,
  input  wire logic [15:0]   source_index_reg,
  input  wire logic [15:0]   dest_index_reg,
  input  wire logic          mem_ack,
  input  wire logic [7:0]    mem_rdata,
  output logic               busy,
  output logic               done,
  output logic               illegal_op,
  output logic [15:0]        result,
  output logic               result_wr,
  output bsbt_flags_t        flags,
  output bsbt_mem_req_t      mem
);

  //////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic is_escape(input logic [7:0] b);
    return b == `BSBT_OPC_ESCAPE;
  endfunction

  // Returns {sign, zero, parity} for byte or word results
  function automatic logic [2:0] szp(input logic [15:0] v,
                                     input logic        w);
    logic s;
    logic z;
    s = w ? v[15] : v[7];
    z = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
    return {s, z, ~^v[7:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State

  bsbt_state_t   state_r, state_nxt;
  bsbt_flags_t   flags_r, flags_nxt;
  bsbt_mem_req_t mem_r, mem_nxt;
  logic [15:0]   result_r, result_nxt;
  logic [7:0]    idx_r, idx_nxt;
  logic [7:0]    nbytes_r, nbytes_nxt;
  logic [7:0]    dbyte_r, dbyte_nxt;
  logic          borrow_r, borrow_nxt;
  logic          allz_r, allz_nxt;
  logic          done_r, done_nxt;
  logic          wr_r, wr_nxt;
  logic          ill_r, ill_nxt;

  logic [7:0]    accum_low_byte;
  logic          accept;
  logic          probe_ok;
  logic          bcd_ok;
  logic [7:0]    bit_src;
  logic [3:0]    probe_idx;
  logic [15:0]   sb_d;
  logic [16:0]   sb_w;
  logic [8:0]    sb_b;
  logic [4:0]    sb_a;
  logic [15:0]   sb_res;
  logic [15:0]   and_res;
  logic [8:0]    cnt9;
  logic [7:0]    idx_inc;
  logic [7:0]    bcd_diff;
  logic          bcd_bout;

  assign accum_low_byte = accum_word[7:0];
  assign accept         = start && (state_r == BSBT_S_IDLE);
  assign idx_inc        = idx_r + 8'h01;

  // Fixed escape and base bits, width and immediate bits left free by the mask, zero middle field
  assign probe_ok = is_escape(opc0)
                 && ((opc1 & `BSBT_PROBE_MASK) == `BSBT_PROBE_BASE)
                 && (opc2[5:3] == 3'h0);
  assign bcd_ok   = is_escape(opc0) && (opc1 == `BSBT_OPC_BCDSUB);

  // Byte width keeps 3 index bits, word width 4
  // Immediate comes from the fourth or last byte
  assign bit_src   = opc1[`BSBT_PROBE_IMM_BIT] ? imm_byte : count_low_reg;
  assign probe_idx = opc1[`BSBT_PROBE_W_BIT] ? bit_src[3:0]
                                             : {1'b0, bit_src[2:0]};

  // Accumulator form takes AL or the full accumulator
  assign sb_d = acc_form ? accum_word : dst_operand;
  assign sb_w = {1'b0, sb_d} - {1'b0, src_operand}
              - {16'h0000, flags_r.carry_flag};
  assign sb_b = {1'b0, sb_d[7:0]} - {1'b0, src_operand[7:0]}
              - {8'h00, flags_r.carry_flag};
  assign sb_a = {1'b0, sb_d[3:0]} - {1'b0, src_operand[3:0]}
              - {4'h0, flags_r.carry_flag};
  assign sb_res  = op_word ? sb_w[15:0] : {sb_d[15:8], sb_b[7:0]};
  assign and_res = dst_operand & src_operand;
  assign cnt9    = {1'b0, count_low_reg} + 9'h001;

  bsbt_bcd_byte_sub u_bcd
  (
    .minuend    (dbyte_r),
    .subtrahend (mem_rdata),
    .borrow_in  (borrow_r),
    .diff       (bcd_diff),
    .borrow_out (bcd_bout)
  );

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_nxt  = state_r;
    flags_nxt  = flags_r;
    mem_nxt    = mem_r;
    result_nxt = result_r;
    idx_nxt    = idx_r;
    nbytes_nxt = nbytes_r;
    dbyte_nxt  = dbyte_r;
    borrow_nxt = borrow_r;
    allz_nxt   = allz_r;
    done_nxt   = 1'b0;
    wr_nxt     = 1'b0;
    ill_nxt    = 1'b0;
    case (state_r)
      BSBT_S_IDLE:
      begin
        if (start)
        begin
          case (op)
            BSBT_OP_SUBTRACT_WITH_BORROW:
            begin
              result_nxt = sb_res;
              flags_nxt.carry_flag     = op_word ? sb_w[16] : sb_b[8];
              flags_nxt.aux_carry_flag = sb_a[4];
              flags_nxt.ovf_flag = op_word
                ? ((sb_d[15] ^ src_operand[15]) & (sb_d[15] ^ sb_w[15]))
                : ((sb_d[7] ^ src_operand[7]) & (sb_d[7] ^ sb_b[7]));
              {flags_nxt.sign_flag, flags_nxt.zero_flag,
               flags_nxt.parity_flag} = szp(sb_res, op_word);
              wr_nxt   = 1'b1;
              done_nxt = 1'b1;
            end
            BSBT_OP_TEST:
            begin
              // Aux carry is undefined, so it is simply left alone
              flags_nxt.carry_flag = 1'b0;
              flags_nxt.ovf_flag   = 1'b0;
              {flags_nxt.sign_flag, flags_nxt.zero_flag,
               flags_nxt.parity_flag} = szp(and_res, op_word);
              done_nxt = 1'b1;
            end
            BSBT_OP_PROBE:
            begin
              if (probe_ok)
              begin
                flags_nxt.zero_flag  = ~dst_operand[probe_idx];
                flags_nxt.carry_flag = 1'b0;
                flags_nxt.ovf_flag   = 1'b0;
                done_nxt = 1'b1;
              end
              else
                ill_nxt = 1'b1;
            end
            BSBT_OP_BCDSUB:
            begin
              if (!bcd_ok)
                ill_nxt = 1'b1;
              else if (cnt9[8:1] == 8'h00)
                done_nxt = 1'b1;
              else
              begin
                // Odd counts round up to whole bytes
                nbytes_nxt = cnt9[8:1];
                idx_nxt    = 8'h00;
                borrow_nxt = 1'b0;
                allz_nxt   = 1'b1;
                mem_nxt    = '{1'b1, 1'b0, 1'b1, dest_index_reg, 8'h00};
                state_nxt  = BSBT_S_RD_DST;
              end
            end
            BSBT_OP_XLAT:
            begin
              mem_nxt = '{1'b1, 1'b0, 1'b0,
                          base_word_reg + {8'h00, accum_low_byte},
                          8'h00};
              state_nxt = BSBT_S_XL_RD;
            end
            default:
              ill_nxt = 1'b1;
          endcase
        end
      end
      BSBT_S_RD_DST:
      begin
        if (mem_ack)
        begin
          dbyte_nxt = mem_rdata;
          mem_nxt   = '{1'b1, 1'b0, 1'b0,
                        source_index_reg + {8'h00, idx_r}, 8'h00};
          state_nxt = BSBT_S_RD_SRC;
        end
      end
      BSBT_S_RD_SRC:
      begin
        if (mem_ack)
        begin
          borrow_nxt = bcd_bout;
          allz_nxt   = allz_r && (bcd_diff == 8'h00);
          // Writes always target the destination segment
          mem_nxt    = '{1'b1, 1'b1, 1'b1,
                         dest_index_reg + {8'h00, idx_r}, bcd_diff};
          state_nxt  = BSBT_S_WR;
        end
      end
      BSBT_S_WR:
      begin
        if (mem_ack)
        begin
          idx_nxt = idx_inc;
          if (idx_inc == nbytes_r)
          begin
            // Flags reflect the full rounded byte count
            flags_nxt.carry_flag = borrow_r;
            flags_nxt.zero_flag  = allz_r;
            mem_nxt   = '0;
            done_nxt  = 1'b1;
            state_nxt = BSBT_S_IDLE;
          end
          else
          begin
            mem_nxt   = '{1'b1, 1'b0, 1'b1,
                          dest_index_reg + {8'h00, idx_inc}, 8'h00};
            state_nxt = BSBT_S_RD_DST;
          end
        end
      end
      BSBT_S_XL_RD:
      begin
        if (mem_ack)
        begin
          result_nxt = {accum_word[15:8], mem_rdata};
          mem_nxt    = '0;
          wr_nxt     = 1'b1;
          done_nxt   = 1'b1;
          state_nxt  = BSBT_S_IDLE;
        end
      end
      default:
      begin
        mem_nxt   = '0;
        state_nxt = BSBT_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r  <= BSBT_S_IDLE;
      flags_r  <= `BSBT_FLAGS_RST;
      mem_r    <= '0;
      result_r <= `BSBT_RESULT_RST;
      idx_r    <= 8'h00;
      nbytes_r <= 8'h00;
      dbyte_r  <= 8'h00;
      borrow_r <= 1'b0;
      allz_r   <= 1'b1;
      done_r   <= 1'b0;
      wr_r     <= 1'b0;
      ill_r    <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      flags_r  <= flags_nxt;
      mem_r    <= mem_nxt;
      result_r <= result_nxt;
      idx_r    <= idx_nxt;
      nbytes_r <= nbytes_nxt;
      dbyte_r  <= dbyte_nxt;
      borrow_r <= borrow_nxt;
      allz_r   <= allz_nxt;
      done_r   <= done_nxt;
      wr_r     <= wr_nxt;
      ill_r    <= ill_nxt;
    end
  end

  assign busy       = (state_r != BSBT_S_IDLE);
  assign done       = done_r;
  assign illegal_op = ill_r;
  assign result     = result_r;
  assign result_wr  = wr_r;
  assign flags      = flags_r;
  assign mem        = mem_r;

  //////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_bcd_go;
    accept && (op == BSBT_OP_BCDSUB) && bcd_ok && (cnt9[8:1] != 8'h00);
  endsequence

  sequence s_bcd_last;
    (state_r == BSBT_S_WR) && mem_ack && (idx_inc == nbytes_r);
  endsequence

  property p_bcd_even;
    @(posedge clk_sys) disable iff (!rst_b)
    s_bcd_go |=> (nbytes_r == ($past(count_low_reg) >> 1)
                  + {7'h00, $past(count_low_reg[0])});
  endproperty
  a_bcd_even: assert property (p_bcd_even)
    else $error("string byte count not rounded up");

  property p_bcd_dseg;
    @(posedge clk_sys) disable iff (!rst_b)
    (mem_r.req && mem_r.we) |-> mem_r.dseg;
  endproperty
  a_bcd_dseg: assert property (p_bcd_dseg)
    else $error("string write outside destination segment");

  property p_bcd_end;
    @(posedge clk_sys) disable iff (!rst_b)
    s_bcd_last |=> done_r && !busy && !mem_r.req
      && (flags_r.carry_flag == $past(borrow_r))
      && (flags_r.zero_flag == $past(allz_r));
  endproperty
  a_bcd_end: assert property (p_bcd_end)
    else $error("string flags do not match final borrow");

  property p_subtract_with_borrow_word;
    @(posedge clk_sys) disable iff (!rst_b)
    (accept && (op == BSBT_OP_SUBTRACT_WITH_BORROW) && op_word) |=> done_r && wr_r
      && (result_r == $past(sb_d) - $past(src_operand)
                      - {15'h0000, $past(flags_r.carry_flag)});
  endproperty
  a_subtract_with_borrow_word: assert property (p_subtract_with_borrow_word)
    else $error("borrow subtract word result wrong");

  property p_subtract_with_borrow_byte_acc;
    @(posedge clk_sys) disable iff (!rst_b)
    (accept && (op == BSBT_OP_SUBTRACT_WITH_BORROW) && !op_word && acc_form)
      |=> (result_r[15:8] == $past(accum_word[15:8]));
  endproperty
  a_subtract_with_borrow_byte_acc: assert property (p_subtract_with_borrow_byte_acc)
    else $error("byte accumulator form touched high byte");

  property p_test;
    @(posedge clk_sys) disable iff (!rst_b)
    (accept && (op == BSBT_OP_TEST) && !op_word) |=> done_r && !wr_r
      && !flags_r.carry_flag && !flags_r.ovf_flag
      && (flags_r.zero_flag == ($past(and_res[7:0]) == 8'h00));
  endproperty
  a_test: assert property (p_test)
    else $error("AND compare flags wrong");

  property p_probe;
    @(posedge clk_sys) disable iff (!rst_b)
    (accept && (op == BSBT_OP_PROBE) && probe_ok) |=> done_r
      && (flags_r.zero_flag == !$past(dst_operand[probe_idx]))
      && !flags_r.carry_flag && !flags_r.ovf_flag;
  endproperty
  a_probe: assert property (p_probe)
    else $error("probe zero flag wrong");

  // Byte width index rebuilt from the raw inputs, so a byte width slip in probe_idx shows here
  property p_probe_byte_idx;
    @(posedge clk_sys) disable iff (!rst_b)
    (accept && (op == BSBT_OP_PROBE) && probe_ok
      && !opc1[`BSBT_PROBE_W_BIT])
      |=> (flags_r.zero_flag == !$past(dst_operand[
            opc1[`BSBT_PROBE_IMM_BIT] ? imm_byte[2:0]
                                      : count_low_reg[2:0]]));
  endproperty
  a_probe_byte_idx: assert property (p_probe_byte_idx)
    else $error("byte probe index exceeds 7");

  property p_probe_bad;
    @(posedge clk_sys) disable iff (!rst_b)
    (accept && (op == BSBT_OP_PROBE) && !probe_ok)
      |=> ill_r && !done_r && $stable(flags_r);
  endproperty
  a_probe_bad: assert property (p_probe_bad)
    else $error("bad probe code was executed");

  property p_xlat;
    @(posedge clk_sys) disable iff (!rst_b)
    (state_r == BSBT_S_XL_RD) |=> $stable(flags_r)
      && (result_r[15:8] == $past(accum_word[15:8]) || !done_r);
  endproperty
  a_xlat: assert property (p_xlat)
    else $error("table lookup changed flags or high byte");

endmodule

`default_nettype wire

// ==== verilog/bsbt_defines.svh ====
// Constants for the decimal subtract, borrow, test and lookup datapath.
// Assumes inclusion by bare name from the main module.
`ifndef BSBT_DEFINES_SVH
`define BSBT_DEFINES_SVH

`define BSBT_OPC_ESCAPE    8'h0F
`define BSBT_OPC_BCDSUB    8'h22
`define BSBT_PROBE_MASK    8'hF6
`define BSBT_PROBE_BASE    8'h10
`define BSBT_PROBE_IMM_BIT 3
`define BSBT_PROBE_W_BIT   0
`define BSBT_MAX_DIGITS    8'hFE
`define BSBT_FLAGS_RST     6'h00
`define BSBT_RESULT_RST    16'h0000

`endif

// ==== verilog/bsbt_pkg.sv ====
// Types shared by the datapath modules.
// Assumes the defines header sits alongside.
`default_nettype none

package bsbt_pkg;

  typedef enum logic [2:0] {
    BSBT_OP_SUBTRACT_WITH_BORROW,
    BSBT_OP_TEST,
    BSBT_OP_PROBE,
    BSBT_OP_BCDSUB,
    BSBT_OP_XLAT
  } bsbt_op_t;

  typedef enum {
    BSBT_S_IDLE,
    BSBT_S_RD_DST,
    BSBT_S_RD_SRC,
    BSBT_S_WR,
    BSBT_S_XL_RD
  } bsbt_state_t;

  typedef struct packed {
    logic aux_carry_flag;
    logic carry_flag;
    logic ovf_flag;
    logic parity_flag;
    logic sign_flag;
    logic zero_flag;
  } bsbt_flags_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        dseg;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bsbt_mem_req_t;

endpackage

`default_nettype wire

// ==== verilog/bsbt_bcd_byte_sub.sv ====
// Packed decimal byte subtractor, two digits with borrow chain.
// Assumes both inputs hold valid decimal digits.
`timescale 1ns/1ps
`default_nettype none

module bsbt_bcd_byte_sub
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       borrow_in,
  output logic      [7:0] diff,
  output logic            borrow_out
);

  logic [4:0] lo;
  logic [4:0] hi;
  logic [3:0] lo_adj;
  logic [3:0] hi_adj;

  // A negative nibble wraps by ten, so 0 - 0 - borrow gives 9
  always_comb
  begin
    lo     = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
    lo_adj = lo[4] ? (lo[3:0] - 4'h6) : lo[3:0];
    hi     = {1'b0, minuend[7:4]} - {1'b0, subtrahend[7:4]} - {4'h0, lo[4]};
    hi_adj = hi[4] ? (hi[3:0] - 4'h6) : hi[3:0];
    diff       = {hi_adj, lo_adj};
    borrow_out = hi[4];
  end

endmodule

`default_nettype wire

// ==== sim/bsbt_mem_model.sv ====
// Byte memory partner for the execution datapath, two segments.
// Assumes the bench preloads and reads ram; only address bits 7:0 used.
`timescale 1ns/1ps
`default_nettype none

module bsbt_mem_model
  import bsbt_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire bsbt_mem_req_t mem,
  input  wire logic [3:0]    lat,
  output logic               mem_ack,
  output logic [7:0]         mem_rdata
);
  logic [7:0] ram [0:1][0:255];
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////////////
  // One answer per request; the cycle after an ack starts a new count
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 8'h5A;
      wait_q    <= 4'h0;
    end
    else if (mem_ack || !mem.req)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata; // No stale data once released
      wait_q    <= 4'h0;
    end
    else if (wait_q >= lat)
    begin
      mem_ack <= 1'b1;
      wait_q  <= 4'h0;
      if (mem.we)
      begin
        ram[mem.dseg][mem.addr[7:0]] <= mem.wdata;
        mem_rdata                    <= ~mem_rdata;
      end
      else
      begin
        mem_rdata <= ram[mem.dseg][mem.addr[7:0]];
      end
    end
    else
    begin
      wait_q    <= wait_q + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

`default_nettype wire

// ==== sim/test_bcd_sub_bit_test_exec.sv ====
// Self-checking bench for the execution datapath.
// Assumes bsbt_mem_model answers the byte memory port.
`timescale 1ns/1ps
`default_nettype none

module test_bcd_sub_bit_test_exec
  import bsbt_pkg::*;
  ;
  logic          clk_sys, rst_b, start, op_word, acc_form, mem_ack;
  logic          busy, done, illegal_op, result_wr, wr_seen, ill_seen, b;
  logic          allz;
  bsbt_op_t      op;
  logic [7:0]    opc0, opc1, opc2, imm_byte, count_low_reg, mem_rdata, rv;
  logic [15:0]   dst_operand, src_operand, accum_word, base_word_reg;
  logic [15:0]   source_index_reg, dest_index_reg, result, exp_res, d, a;
  logic [15:0]   lfsr_q;
  logic [3:0]    lat, sel;
  bsbt_flags_t   flags, exp_f;
  bsbt_mem_req_t mem;
  int            num_errors, tests_run;
  logic [23:0]   bad_opc [0:4] = '{24'h0E_10C0, 24'h0F_14C0, 24'h0F_11C8,
                                   24'h0F_2300, 24'h0E_2200};
  logic [7:0]    bcd_cnt [0:6] = '{8'h01, 8'h04, 8'h03, 8'hFE, 8'h02,
                                   8'h2B, 8'h00};

  bsbt_exec i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .start(start), .op(op),
    .op_word(op_word), .acc_form(acc_form), .opc0(opc0), .opc1(opc1),
    .opc2(opc2), .imm_byte(imm_byte), .dst_operand(dst_operand),
    .src_operand(src_operand), .count_low_reg(count_low_reg),
    .accum_word(accum_word), .base_word_reg(base_word_reg),
    .source_index_reg(source_index_reg), .dest_index_reg(dest_index_reg),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
    .illegal_op(illegal_op), .result(result), .result_wr(result_wr),
    .flags(flags), .mem(mem));

  bsbt_mem_model i_mem (.clk_sys(clk_sys), .rst_b(rst_b), .mem(mem),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction

  function automatic logic [7:0] bcd_rnd();
    logic [15:0] r;
    r = rnd();
    return {4'(r[7:0] % 8'h0A), 4'(r[15:8] % 8'h0A)};
  endfunction

  function automatic logic [21:0] exp_subtract_with_borrow(input logic w,
    input logic [15:0] dv, input logic [15:0] s, input logic c);
    logic [16:0] r;
    logic [8:0]  rb;
    logic [4:0]  n;
    bsbt_flags_t f;
    r = {1'b0, dv} - {1'b0, s} - 17'(c);
    rb = {1'b0, dv[7:0]} - {1'b0, s[7:0]} - 9'(c);
    n = {1'b0, dv[3:0]} - {1'b0, s[3:0]} - 5'(c);
    f.aux_carry_flag = n[4];
    f.carry_flag = w ? r[16] : rb[8];
    f.ovf_flag = w ? (dv[15] ^ s[15]) & (dv[15] ^ r[15])
                   : (dv[7] ^ s[7]) & (dv[7] ^ rb[7]);
    f.parity_flag = ~^rb[7:0];
    f.sign_flag = w ? r[15] : rb[7];
    f.zero_flag = w ? (r[15:0] == 16'h0000) : (rb[7:0] == 8'h00);
    return {f, w ? r[15:0] : {dv[15:8], rb[7:0]}};
  endfunction

  function automatic bsbt_flags_t exp_test(input logic w,
    input logic [15:0] dv, input logic [15:0] s, input bsbt_flags_t f0);
    logic [15:0] v;
    bsbt_flags_t f;
    v = dv & s;
    f = f0;
    f.carry_flag = 1'b0;
    f.ovf_flag = 1'b0;
    f.parity_flag = ~^v[7:0];
    f.sign_flag = w ? v[15] : v[7];
    f.zero_flag = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Poke raises start while busy; a wrongly taken request shows in flags
  task automatic run_op(input logic poke);
    int n;
    n = 0;
    @(posedge clk_sys);
    #2 start = 1'b1;
    @(posedge clk_sys);
    #2;
    while (done !== 1'b1 && illegal_op !== 1'b1 && n < 3000)
    begin
      start = poke & (busy === 1'b1);
      if (poke && busy === 1'b1)
        op = BSBT_OP_TEST;
      @(posedge clk_sys);
      #2;
      n++;
    end
    start = 1'b0;
    wr_seen = result_wr;
    ill_seen = illegal_op;
    if (n >= 3000)
    begin
      num_errors++;
      $display("[ERR] completion expected done seen none");
    end
  endtask

  task automatic do_bcd(input logic [7:0] cnt, input logic [3:0] l);
    int         nb;
    logic [7:0] d8, s8, g8;
    logic [7:0] e8 [0:127];
    logic [4:0] t;
    nb = (int'(cnt) + 1) / 2;
    lat = l;
    for (int i = 0; i <= nb; i++)
    begin
      i_mem.ram[1][32+i] = bcd_rnd();
      i_mem.ram[0][80+i] = bcd_rnd();
    end
    if (cnt[0])
    begin
      i_mem.ram[1][32+nb-1][7:4] = 4'h0;
      i_mem.ram[0][80+nb-1][7:4] = 4'h0;
    end
    b = 1'b0;
    allz = 1'b1;
    for (int i = 0; i < nb; i++)
    begin
      d8 = i_mem.ram[1][32+i];
      s8 = i_mem.ram[0][80+i];
      t = {1'b0, d8[3:0]} - {1'b0, s8[3:0]} - 5'(b);
      b = t[4];
      e8[i][3:0] = b ? 4'(t + 5'h0A) : t[3:0];
      t = {1'b0, d8[7:4]} - {1'b0, s8[7:4]} - 5'(b);
      b = t[4];
      e8[i][7:4] = b ? 4'(t + 5'h0A) : t[3:0];
      allz = allz & (e8[i] == 8'h00);
    end
    g8 = i_mem.ram[1][32+nb];
    op = BSBT_OP_BCDSUB;
    opc0 = 8'h0F;
    opc1 = 8'h22;
    count_low_reg = cnt;
    dest_index_reg = 16'h0020;
    source_index_reg = 16'h0050;
    run_op(1'b0);
    check("bcd illegal", 16'(ill_seen), 16'h0000);
    check("bcd idle", 16'({busy, mem.req}), 16'h0000);
    for (int i = 0; i < nb; i++)
      check("bcd byte", 16'(i_mem.ram[1][32+i]), 16'(e8[i]));
    check("bcd guard", 16'(i_mem.ram[1][32+nb]), 16'(g8));
    exp_f.carry_flag = b;
    exp_f.zero_flag = allz;
    if (cnt != 8'h00)
      check("bcd flags", 16'(flags), 16'(exp_f));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (50000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    {rst_b, start, op_word, acc_form, opc0, opc1, opc2} = '0;
    {imm_byte, count_low_reg, dst_operand, src_operand} = '0;
    {accum_word, base_word_reg, source_index_reg, dest_index_reg} = '0;
    op = BSBT_OP_SUBTRACT_WITH_BORROW;
    lat = 4'h0;
    lfsr_q = 16'h0017;
    num_errors = 0;
    tests_run = 0;
    exp_f = '0;
    exp_res = 16'h0000;
    repeat (20) @(posedge clk_sys);
    #2 rst_b = 1'b1;
    for (int k = 0; k < 48; k++)
    begin
      op = k[0] ? BSBT_OP_TEST : BSBT_OP_SUBTRACT_WITH_BORROW;
      op_word = k[1];
      acc_form = k[2] & ~k[0];
      dst_operand = rnd();
      src_operand = (k % 7 == 0) ? dst_operand : rnd();
      accum_word = rnd();
      d = acc_form ? accum_word : dst_operand;
      if (k[0])
        exp_f = exp_test(op_word, d, src_operand, exp_f);
      else
        {exp_f, exp_res} = exp_subtract_with_borrow(op_word, d, src_operand, exp_f.carry_flag);
      run_op(1'b0);
      check("alu flags", 16'(flags), 16'(exp_f));
      check("alu result", result, exp_res);
      check("alu write", 16'(wr_seen), 16'(!k[0]));
    end
    for (int k = 0; k < 32; k++)
    begin
      op = BSBT_OP_PROBE;
      opc0 = 8'h0F;
      opc1 = {4'h1, k[1], 2'b00, k[0]};
      a = rnd();
      opc2 = {a[7:6], 3'b000, a[2:0]};
      count_low_reg = a[15:8];
      dst_operand = rnd();
      imm_byte = 8'(rnd());
      sel = k[1] ? imm_byte[3:0] : count_low_reg[3:0];
      sel = sel & (k[0] ? 4'hF : 4'h7);
      exp_f.carry_flag = 1'b0;
      exp_f.ovf_flag = 1'b0;
      exp_f.zero_flag = ~dst_operand[sel];
      run_op(1'b0);
      check("probe", 16'(flags), 16'(exp_f));
      check("probe ok", 16'(ill_seen), 16'h0000);
      check("probe res", result, exp_res);
    end
    for (int k = 0; k < 5; k++)
    begin
      op = (k < 3) ? BSBT_OP_PROBE : BSBT_OP_BCDSUB;
      {opc0, opc1, opc2} = bad_opc[k];
      count_low_reg = 8'h04;
      dst_operand = rnd();
      run_op(1'b0);
      check("bad code", 16'(ill_seen), 16'h0001);
      check("bad flags", 16'(flags), 16'(exp_f));
    end
    for (int k = 0; k < 6; k++)
    begin
      op = BSBT_OP_XLAT;
      base_word_reg = rnd();
      accum_word = rnd();
      dst_operand = 16'h0000;
      src_operand = 16'h0000;
      a = base_word_reg + {8'h00, accum_word[7:0]};
      rv = 8'(rnd());
      i_mem.ram[0][a[7:0]] = rv;
      i_mem.ram[1][a[7:0]] = rv;
      exp_res = {accum_word[15:8], rv};
      lat = 4'(k);
      run_op(k[0]);
      check("lookup", result, exp_res);
      check("lookup flags", 16'(flags), 16'(exp_f));
      check("lookup write", 16'(wr_seen), 16'h0001);
    end
    for (int k = 0; k < 7; k++)
      do_bcd(bcd_cnt[k], 4'(k % 5));
    print_verdict();
  end
endmodule

`default_nettype wire
